// ### iore_engine.sv
// Target engine: services read, write, atomic and maintenance requests.
// Assumes the requester keeps identifier rules and holds inputs while valid.
// Notes on behaviour
// - A request needing a reply gets a response once finished or failed.
// - Success response reports completion and carries read data for read types.
// - Unrecoverable failure returns an error response instead of success.
// - Out-of-sequence requests are accepted but complete only in sequence order.
// - Short payloads are padded and sit in their proper byte lanes.
// - A read returns exactly the requested lanes, others zero.
// - Memory is accessed regardless of any coherence state.
// - Plain writes allow byte, half-word, word and double-word lane masks.
// - Stream writes carry whole double-words only.
// - Plain and stream writes never produce a response.
// - Acked write performs the write then responds done.
// - Atomic reads, returns old data, modifies and writes back without interruption.
// - Supports increment, decrement, test-and-swap, set, clear, swap, compare-and-swap.
// - Maintenance accesses answer with maintenance-type responses.
// - Maintenance accesses use 32-bit quantities.
// - Writes complete in delivery order, or in sequence order when seq_en_i is set.
// - A read completes after all earlier writes, or after all writes earlier in sequence when seq_en_i is set.
// - Payloads are big-endian; little-endian local memory is byte-swapped.
`timescale 1ns/1ps
module iore_engine
  import iore_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic seq_en_i,
  input wire logic local_le_i,
  input wire logic req_vld_i,
  input wire iore_req_s req_i,
  output logic req_rdy_o,
  output logic rsp_vld_o,
  input wire logic rsp_rdy_i,
  output iore_rsp_s rsp_o,
  output logic [SEQ_W-1:0] exp_seq_o
);

  typedef enum logic [1:0] {S_IDLE, S_CHK, S_EXEC, S_RESP} iore_fsm_e;

  typedef struct packed {
    iore_fsm_e fsm;
    iore_req_s cur;
    logic park_v;
    iore_req_s park;
    logic [SEQ_W-1:0] exp;
    logic [MREG_N-1:0][31:0] mreg;
    iore_rsp_s rsp;
  } iore_state_s;

  iore_state_s q_ff;
  iore_state_s nxt_q;

  logic mem_en;
  logic mem_we;
  logic [LANES-1:0] mem_be;
  logic [DW-1:0] mem_wdata;
  logic [DW-1:0] mem_rdata;
  logic [DW-1:0] rd_be;

  function automatic logic [DW-1:0] lane_bits(input logic [LANES-1:0] be);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[DW-1-8*i -: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Byte swap for a little-endian local store
  function automatic logic [DW-1:0] bswap(input logic [DW-1:0] d);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < LANES; i++) begin
      r[8*i +: 8] = d[DW-1-8*i -: 8];
    end
    return r;
  endfunction

  function automatic logic [LANES-1:0] lswap(input logic [LANES-1:0] b);
    logic [LANES-1:0] r;
    r = '0;
    for (int i = 0; i < LANES; i++) begin
      r[i] = b[LANES-1-i];
    end
    return r;
  endfunction

  function automatic logic atom_size_ok(input logic [LANES-1:0] be);
    logic ok;
    ok = $onehot(be) || (be inside {BE_HALF0, BE_HALF1, BE_HALF2, BE_HALF3, BE_WORD_HI, BE_WORD_LO});
    return ok;
  endfunction

  function automatic logic is_atomic(input iore_kind_e k);
    return k inside {atom_inc, atom_dec, atom_set, atom_clr, atom_swap, atom_tswap, atom_cswap};
  endfunction

  // Shift that brings the lowest-order selected lane down to bit 0
  function automatic logic [5:0] lane_shift(input logic [LANES-1:0] be);
    logic [5:0] s;
    s = '0;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        s = 6'((LANES-1-i)*8);
      end
    end
    return s;
  endfunction

  // Carry out of the field is discarded by the final lane mask
  function automatic logic [DW-1:0] atom_calc(input iore_req_s r, input logic [DW-1:0] old);
    logic [DW-1:0] lm;
    logic [DW-1:0] one;
    logic [DW-1:0] res;
    lm = lane_bits(r.be);
    one = ONE64 << lane_shift(r.be);
    res = old;
    unique case (r.kind)
      atom_inc: res = old + one;
      atom_dec: res = old - one;
      atom_set: res = '1;
      atom_clr: res = '0;
      atom_swap: res = r.wdata;
      atom_tswap: res = ((old & lm) == '0) ? r.wdata : old;
      atom_cswap: res = ((old & lm) == (r.wdata & lm)) ? r.sdata : old;
      default: res = old;
    endcase
    return res & lm;
  endfunction

  function automatic logic req_err(input iore_req_s r);
    logic e;
    e = 1'b0;
    if (r.kind inside {maint_read, maint_write}) begin
      e = !(r.be inside {BE_WORD_HI, BE_WORD_LO}) || (r.addr >= ADDR_W'(MREG_N));
    end else begin
      e = (r.addr >= ADDR_W'(MEM_DEPTH)) || (r.be == '0);
      if (is_atomic(r.kind) && !atom_size_ok(r.be)) begin
        e = 1'b1;
      end
      if (r.kind == stream_write_request && r.be != BE_FULL) begin
        e = 1'b1;
      end
    end
    return e;
  endfunction

  logic in_order;
  logic park_go;
  logic cur_err;

  assign park_go = q_ff.park_v && (!seq_en_i || q_ff.park.seq == q_ff.exp);
  assign in_order = !seq_en_i || req_i.seq == q_ff.exp;
  // A single parking slot: only one early request may wait at a time
  // Handshakes drop while the clock enable holds the engine, so no beat is taken and then lost
  assign req_rdy_o = ce_i && (q_ff.fsm == S_IDLE) && !park_go && (in_order || !q_ff.park_v);
  assign cur_err = req_err(q_ff.cur);
  assign rsp_vld_o = ce_i && (q_ff.fsm == S_RESP);
  assign rsp_o = q_ff.rsp;
  assign exp_seq_o = q_ff.exp;
  assign rd_be = lane_bits(q_ff.cur.be);

  always_comb begin
    logic [DW-1:0] old;
    logic [31:0] mword;
    nxt_q = q_ff;
    mem_en = 1'b0;
    mem_we = 1'b0;
    mem_be = local_le_i ? lswap(q_ff.cur.be) : q_ff.cur.be;
    mem_wdata = local_le_i ? bswap(q_ff.cur.wdata) : q_ff.cur.wdata;
    old = local_le_i ? bswap(mem_rdata) : mem_rdata;
    mword = q_ff.cur.be[0] ? q_ff.cur.wdata[63:32] : q_ff.cur.wdata[31:0];
    unique case (q_ff.fsm)
      S_IDLE: begin
        if (park_go) begin
          nxt_q.cur = q_ff.park;
          nxt_q.park_v = 1'b0;
          nxt_q.fsm = S_CHK;
        end else if (req_vld_i && req_rdy_o) begin
          if (in_order) begin
            nxt_q.cur = req_i;
            nxt_q.fsm = S_CHK;
          end else begin
            nxt_q.park = req_i;
            nxt_q.park_v = 1'b1;
          end
        end
      end
      S_CHK: begin
        nxt_q.rsp.tid = q_ff.cur.tid;
        nxt_q.rsp.be = q_ff.cur.be;
        nxt_q.rsp.data = '0;
        nxt_q.rsp.st = rsp_done;
        nxt_q.fsm = S_RESP;
        if (q_ff.cur.kind inside {maint_read, maint_write}) begin
          nxt_q.rsp.st = cur_err ? rsp_maint_error : rsp_maint_done;
          if (!cur_err) begin
            if (q_ff.cur.kind == maint_write) begin
              nxt_q.mreg[q_ff.cur.addr[MREG_AW-1:0]] = mword;
            end else begin
              nxt_q.rsp.data = {2{q_ff.mreg[q_ff.cur.addr[MREG_AW-1:0]]}} & rd_be;
            end
          end
        end else if (cur_err) begin
          nxt_q.rsp.st = rsp_error;
          if (q_ff.cur.kind inside {plain_write_request, stream_write_request}) begin
            nxt_q.fsm = S_IDLE;
          end
        end else if (q_ff.cur.kind inside {plain_write_request, stream_write_request, acked_write_request}) begin
          // Single-issue engine keeps writes and later reads in delivery order, or in sequence order when seq_en_i is set
          mem_en = 1'b1;
          mem_we = 1'b1;
          if (q_ff.cur.kind != acked_write_request) begin
            nxt_q.fsm = S_IDLE;
          end
        end else begin
          mem_en = 1'b1;
          nxt_q.fsm = S_EXEC;
        end
        if (nxt_q.fsm == S_IDLE && seq_en_i) begin
          nxt_q.exp = q_ff.exp + 1'b1;
        end
      end
      S_EXEC: begin
        nxt_q.rsp.data = old & rd_be;
        nxt_q.fsm = S_RESP;
        if (is_atomic(q_ff.cur.kind)) begin
          // Nothing else reaches memory between this read and write-back
          mem_en = 1'b1;
          mem_we = 1'b1;
          mem_wdata = local_le_i ? bswap(atom_calc(q_ff.cur, old)) : atom_calc(q_ff.cur, old);
        end
      end
      S_RESP: begin
        if (rsp_rdy_i) begin
          nxt_q.fsm = S_IDLE;
          if (seq_en_i) begin
            nxt_q.exp = q_ff.exp + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else if (ce_i) begin
      q_ff <= nxt_q;
    end
  end

  iore_mem u_mem (
    .mclk_i(mclk_i),
    .ce_i(ce_i),
    .en_i(mem_en),
    .we_i(mem_we),
    .be_i(mem_be),
    .addr_i(q_ff.cur.addr[MEM_AW-1:0]),
    .wdata_i(mem_wdata),
    .rdata_o(mem_rdata)
  );

  // Checks assume ce_i stays high
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_write_no_resp: assert property (
    (q_ff.fsm == S_CHK && q_ff.cur.kind inside {plain_write_request, stream_write_request})
    |=> !rsp_vld_o) else $error("plain or stream write produced a response");

  a_rsp_tid_match: assert property (
    rsp_vld_o |-> rsp_o.tid == q_ff.cur.tid) else $error("response identifier mismatch");

  a_read_exact_size: assert property (
    (rsp_vld_o && q_ff.cur.kind == plain_read_request)
    |-> (rsp_o.data & ~lane_bits(rsp_o.be)) == '0 && rsp_o.be == q_ff.cur.be)
    else $error("read data outside requested lanes");

  a_atom_bad_size: assert property (
    (q_ff.fsm == S_CHK && is_atomic(q_ff.cur.kind) && !atom_size_ok(q_ff.cur.be))
    |-> !mem_we ##1 (rsp_vld_o && rsp_o.st == rsp_error)) else $error("bad atomic size not refused");

  a_maint_rsp_type: assert property (
    (rsp_vld_o && q_ff.cur.kind inside {maint_read, maint_write})
    |-> rsp_o.st inside {rsp_maint_done, rsp_maint_error}) else $error("maintenance got normal response");

  a_seq_order: assert property (
    (q_ff.fsm == S_CHK && $past(q_ff.fsm) == S_IDLE && seq_en_i)
    |-> q_ff.cur.seq == q_ff.exp) else $error("request completed out of sequence");

  a_atom_writeback: assert property (
    (q_ff.fsm == S_EXEC && is_atomic(q_ff.cur.kind))
    |-> mem_we ##1 (rsp_vld_o && rsp_o.st == rsp_done)) else $error("atomic did not write back");

  a_read_resp_time: assert property (
    (q_ff.fsm == S_CHK && q_ff.cur.kind == plain_read_request && !cur_err)
    |-> ##2 rsp_vld_o) else $error("read response not in two cycles");

  a_read_err_time: assert property (
    (q_ff.fsm == S_CHK && q_ff.cur.kind == plain_read_request && cur_err)
    |-> ##1 (rsp_vld_o && rsp_o.st == rsp_error)) else $error("failed read not answered with error");

  a_acked_done: assert property (
    (q_ff.fsm == S_CHK && q_ff.cur.kind == acked_write_request && !cur_err)
    |-> mem_we ##1 (rsp_vld_o && rsp_o.st == rsp_done)) else $error("acked write response wrong");

  c_atomic_done: cover property (rsp_vld_o && is_atomic(q_ff.cur.kind) && rsp_o.st == rsp_done);
  c_parked: cover property (q_ff.park_v ##[1:20] park_go);
  c_maint_read: cover property (rsp_vld_o && q_ff.cur.kind == maint_read);
  c_error_rsp: cover property (rsp_vld_o && rsp_o.st == rsp_error);

endmodule

// ### iore_engine_tb_top.sv
// Self-checking bench for the target engine driven through the requester model.
// Assumes the engine holds its memory and maintenance registers internally.
`timescale 1ns/1ps
module iore_engine_tb_top
  import iore_pkg::*;
;
  logic mclk_i, rst_i, ce, seq_en, local_le, req_vld, req_rdy, rsp_vld, rsp_rdy;
  iore_req_s req;
  iore_rsp_s rsp;
  logic [SEQ_W-1:0] exp_seq;
  logic [7:0] tid_n, tid_last;
  int bad_count, samples_checked, cycles;

  iore_engine iore_engine_inst (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .seq_en_i(seq_en),
    .local_le_i(local_le), .req_vld_i(req_vld), .req_i(req), .req_rdy_o(req_rdy), .rsp_vld_o(rsp_vld),
    .rsp_rdy_i(rsp_rdy), .rsp_o(rsp), .exp_seq_o(exp_seq));
  iore_req_model iore_req_model_inst (.mclk_i(mclk_i), .req_rdy_i(req_rdy), .rsp_vld_i(rsp_vld),
    .rsp_i(rsp), .req_vld_o(req_vld), .req_o(req), .rsp_rdy_o(rsp_rdy));

  always #25 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic iore_req_s mk(iore_kind_e k, logic [7:0] a, logic [7:0] b, logic [63:0] w, logic [63:0] s);
    tid_last = tid_n;
    tid_n = tid_n + 8'h01;
    return '{k, tid_last, 4'h0, a, b, w, s};
  endfunction

  task automatic xfer(input iore_req_s q, input int dly, output iore_rsp_s r);
    bit ok;
    iore_req_model_inst.send(q, ok);
    check(ok, 1'b1);
    iore_req_model_inst.get(dly, r, ok);
    check(ok, 1'b1);
  endtask

  task automatic post(input iore_req_s q);
    bit ok;
    iore_req_model_inst.send(q, ok);
    check(ok, 1'b1);
    repeat (4) begin
      @(negedge mclk_i);
      check(rsp_vld, 1'b0);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] b, input logic [63:0] e);
    iore_rsp_s r;
    xfer(mk(plain_read_request, a, b, '0, '0), 0, r);
    check(r.st, rsp_done);
    check(r.tid, tid_last);
    check(r.data, e);
    check(r.be, b);
  endtask

  task automatic t_write_read;
    post(mk(stream_write_request, 8'h03, BE_FULL, 64'h1111_2222_3333_4444, '0));
    post(mk(plain_write_request, 8'h03, BE_HALF0, 64'hFFFF_FFFF_FFFF_ABCD, '0));
    rd(8'h03, BE_FULL, 64'h1111_2222_3333_ABCD);
    rd(8'h03, BE_WORD_LO, 64'h1111_2222_0000_0000);
  endtask

  task automatic t_acked;
    iore_rsp_s r;
    xfer(mk(acked_write_request, 8'h04, BE_FULL, 64'h5555_6666_7777_8888, '0), 3, r);
    check(r.st, rsp_done);
    check(r.tid, tid_last);
    rd(8'h04, BE_FULL, 64'h5555_6666_7777_8888);
  endtask

  // Freezes the engine mid-read, then at idle, through the clock enable
  task automatic t_hold;
    iore_rsp_s r;
    bit ok;
    iore_req_model_inst.send(mk(plain_read_request, 8'h04, BE_FULL, '0, '0), ok);
    check(ok, 1'b1);
    ce = 1'b0;
    repeat (5) begin
      @(negedge mclk_i);
      check(rsp_vld, 1'b0);
    end
    ce = 1'b1;
    iore_req_model_inst.get(0, r, ok);
    check(ok, 1'b1);
    check(r.tid, tid_last);
    check(r.data, 64'h5555_6666_7777_8888);
    @(negedge mclk_i);
    ce = 1'b0;
    @(negedge mclk_i);
    check(req_rdy, 1'b0);
    ce = 1'b1;
  endtask

  task automatic t_atomics;
    iore_kind_e ks[8] = '{atom_inc, atom_dec, atom_set, atom_clr, atom_tswap, atom_cswap, atom_swap, atom_tswap};
    logic [31:0] ws[8] = '{'0, '0, '0, '0, 32'h1234_5678, 32'h1234_5678, 32'h0000_0001, 32'hFFFF_FFFF};
    logic [31:0] ss[8] = '{'0, '0, '0, '0, '0, 32'h9ABC_DEF0, '0, '0};
    logic [31:0] olds[8] = '{'0, 32'h1, '0, 32'hFFFF_FFFF, '0, 32'h1234_5678, 32'h9ABC_DEF0, 32'h1};
    iore_rsp_s r;
    post(mk(stream_write_request, 8'h05, BE_FULL, '0, '0));
    for (int i = 0; i < 8; i++) begin
      xfer(mk(ks[i], 8'h05, BE_WORD_LO, {ws[i], 32'h0}, {ss[i], 32'h0}), 0, r);
      check(r.st, rsp_done);
      check(r.data, {olds[i], 32'h0});
    end
    rd(8'h05, BE_FULL, 64'h0000_0001_0000_0000);
  endtask

  task automatic t_errors;
    iore_rsp_s r;
    xfer(mk(atom_swap, 8'h05, BE_FULL, 64'hDEAD_BEEF_DEAD_BEEF, '0), 0, r);
    check(r.st, rsp_error);
    post(mk(stream_write_request, 8'h05, BE_WORD_LO, 64'hFFFF_FFFF_FFFF_FFFF, '0));
    rd(8'h05, BE_FULL, 64'h0000_0001_0000_0000);
    xfer(mk(plain_read_request, 8'h10, BE_FULL, '0, '0), 0, r);
    check(r.st, rsp_error);
    xfer(mk(maint_write, 8'h01, BE_FULL, '0, '0), 0, r);
    check(r.st, rsp_maint_error);
  endtask

  task automatic t_maint;
    iore_rsp_s r;
    xfer(mk(maint_write, 8'h01, BE_WORD_HI, 64'h0000_0000_A5A5_5A5A, '0), 0, r);
    check(r.st, rsp_maint_done);
    xfer(mk(maint_read, 8'h01, BE_WORD_HI, '0, '0), 0, r);
    check(r.st, rsp_maint_done);
    check(r.data, 64'h0000_0000_A5A5_5A5A);
    xfer(mk(maint_read, 8'h01, BE_WORD_LO, '0, '0), 0, r);
    check(r.data, 64'hA5A5_5A5A_0000_0000);
  endtask

  task automatic t_endian;
    @(negedge mclk_i);
    local_le = 1'b1;
    post(mk(stream_write_request, 8'h07, BE_FULL, 64'h0102_0304_0506_0708, '0));
    rd(8'h07, BE_FULL, 64'h0102_0304_0506_0708);
    @(negedge mclk_i);
    local_le = 1'b0;
    rd(8'h07, BE_FULL, 64'h0807_0605_0403_0201);
  endtask

  task automatic t_seq;
    iore_req_s q0, q1;
    iore_rsp_s r;
    bit ok;
    @(negedge mclk_i);
    rst_i = 1'b1;
    seq_en = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    check(exp_seq, 4'h0);
    q1 = mk(acked_write_request, 8'h08, BE_FULL, 64'h0F0F_0F0F_0F0F_0F0F, '0);
    q1.seq = 4'h1;
    post(q1);
    q0 = mk(plain_read_request, 8'h03, BE_FULL, '0, '0);
    xfer(q0, 0, r);
    check(r.tid, q0.tid);
    check(r.data, 64'h1111_2222_3333_ABCD);
    iore_req_model_inst.get(0, r, ok);
    check(ok, 1'b1);
    check(r.tid, q1.tid);
    check(exp_seq, 4'h2);
    seq_en = 1'b0;
  endtask

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    rst_i = 1'b1;
    ce = 1'b1;
    seq_en = 1'b0;
    local_le = 1'b0;
    tid_n = 8'h00;
    tid_last = 8'h00;
    repeat (20) @(negedge mclk_i);
    rst_i = 1'b0;
    t_write_read();
    $display("write_read done");
    t_acked();
    $display("acked_write done");
    t_hold();
    $display("hold done");
    t_atomics();
    $display("atomics done");
    t_errors();
    $display("errors done");
    t_maint();
    $display("maintenance done");
    t_endian();
    $display("endian done");
    t_seq();
    $display("sequence done");
    end_of_test();
  end
endmodule

// ### iore_mem.sv
// Local double-word memory with byte-lane writes and a registered read port.
// Lane 0 is the most significant byte of the double-word.
`timescale 1ns/1ps
module iore_mem
  import iore_pkg::*;
(
  input wire logic mclk_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic we_i,
  input wire logic [LANES-1:0] be_i,
  input wire logic [MEM_AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_ff [MEM_DEPTH];

  always_ff @(posedge mclk_i) begin
    if (ce_i && en_i) begin
      if (we_i) begin
        for (int i = 0; i < LANES; i++) begin
          if (be_i[i]) begin
            mem_ff[addr_i][DW-1-8*i -: 8] <= wdata_i[DW-1-8*i -: 8];
          end
        end
      end else begin
        rdata_o <= mem_ff[addr_i];
      end
    end
  end

endmodule

// ### iore_pkg.sv
// Shared types and constants for the I/O request/response target engine.
// Assumes a single clock domain; all widths are fixed.
package iore_pkg;

  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int DW = 64;
  localparam int LANES = 8;
  localparam int SEQ_W = 4;
  localparam int TID_W = 8;
  localparam int ADDR_W = 8;
  localparam int MREG_N = 4;
  localparam int MREG_AW = 2;
  localparam logic [7:0] BE_FULL = 8'hFF;
  localparam logic [7:0] BE_WORD_HI = 8'hF0;
  localparam logic [7:0] BE_WORD_LO = 8'h0F;
  localparam logic [7:0] BE_HALF0 = 8'hC0;
  localparam logic [7:0] BE_HALF1 = 8'h30;
  localparam logic [7:0] BE_HALF2 = 8'h0C;
  localparam logic [7:0] BE_HALF3 = 8'h03;
  localparam logic [SEQ_W-1:0] SEQ_RST = 4'h0;
  localparam logic [DW-1:0] ONE64 = 64'h0000_0000_0000_0001;

  typedef enum logic [3:0] {
    plain_read_request,
    plain_write_request,
    acked_write_request,
    stream_write_request,
    atom_inc,
    atom_dec,
    atom_set,
    atom_clr,
    atom_swap,
    atom_tswap,
    atom_cswap,
    maint_read,
    maint_write
  } iore_kind_e;

  typedef enum logic [1:0] {
    rsp_done,
    rsp_error,
    rsp_maint_done,
    rsp_maint_error
  } iore_rsts_e;

  // One request beat; wdata carries the swap/compare value, sdata the compare-and-swap new value
  typedef struct packed {
    iore_kind_e kind;
    logic [TID_W-1:0] tid;
    logic [SEQ_W-1:0] seq;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] be;
    logic [DW-1:0] wdata;
    logic [DW-1:0] sdata;
  } iore_req_s;

  typedef struct packed {
    iore_rsts_e st;
    logic [TID_W-1:0] tid;
    logic [LANES-1:0] be;
    logic [DW-1:0] data;
  } iore_rsp_s;

endpackage

// ### iore_req_model.sv
// Requester model standing on the fabric side of the target engine.
// Assumes a single clock; drives at the falling edge, samples ready at the rising edge and responses at the falling edge.
`timescale 1ns/1ps
module iore_req_model
  import iore_pkg::*;
(
  input wire logic mclk_i,
  input wire logic req_rdy_i,
  input wire logic rsp_vld_i,
  input wire iore_rsp_s rsp_i,
  output logic req_vld_o,
  output iore_req_s req_o,
  output logic rsp_rdy_o
);
  initial begin
    req_vld_o = 1'b0;
    req_o = '0;
    rsp_rdy_o = 1'b0;
  end

  // Callers pick a fresh tid per request and reuse none before its answer
  // Callers send aligned lane masks, 1/2/4-lane atomics except the 8-lane one in t_errors, operands only for swaps
  // Payloads are big-endian double-words padded outside the lanes
  task automatic send(input iore_req_s r, output bit ok);
    int n;
    ok = 1'b0;
    @(negedge mclk_i);
    req_o = r;
    req_vld_o = 1'b1;
    for (n = 0; n < 50 && !ok; n++) begin
      @(posedge mclk_i);
      ok = (req_rdy_i === 1'b1);
    end
    @(negedge mclk_i);
    req_vld_o = 1'b0;
    // Released payload is inverted so a stale value never looks live
    req_o = ~r;
  endtask

  // Delay lets the response stand several cycles before it is taken
  task automatic get(input int dly, output iore_rsp_s r, output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 50 && !ok; n++) begin
      @(negedge mclk_i);
      ok = (rsp_vld_i === 1'b1);
    end
    repeat (dly) @(negedge mclk_i);
    r = rsp_i;
    rsp_rdy_o = ok;
    @(negedge mclk_i);
    rsp_rdy_o = 1'b0;
  endtask
endmodule
